// [compare_mode3_output_control.sv]
// Contract
// - match sets compare output high in mode 3
// - overflow reloads timer and clears output
// - coinciding overflow and match leave output unchanged
// - reload, timer, control back to back: stuck low
// - timer before reload keeps normal toggling
// - idle slot before control access avoids stuck
// - timer preloaded compare minus one matches next
`timescale 1ns/1ns
module compare_mode3_output_control #(
  parameter int unsigned TIMER_WIDTH = compare_mode3_pkg::TIMER_WIDTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             compare_out
);

  compare_mode3_pkg::control_t     control;
  compare_mode3_pkg::timer_event_t events;
  compare_mode3_pkg::preload_seq_t seq;

  logic [TIMER_WIDTH-1:0] timer_reload_value;
  logic [TIMER_WIDTH-1:0] channel_compare_value;
  logic [TIMER_WIDTH-1:0] count;
  logic                   stuck_low;
  logic                   match_flag;
  logic                   overflow_flag;
  logic                   done_last;
  logic                   xfer_back_to_back;
  logic                   timer_load;

  logic                   setup;
  logic                   access;
  logic                   wr;
  logic                   rd;
  logic                   mapped;
  logic                   wr_control;
  logic                   wr_timer;
  logic                   wr_reload;
  logic                   wr_compare;
  logic                   wr_status;
  logic                   touch_control;
  logic                   data_eq_compare;
  logic [31:0]            next_rdata;

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == compare_mode3_pkg::OFFSET_CONTROL ||
           addr == compare_mode3_pkg::OFFSET_TIMER   ||
           addr == compare_mode3_pkg::OFFSET_RELOAD  ||
           addr == compare_mode3_pkg::OFFSET_COMPARE ||
           addr == compare_mode3_pkg::OFFSET_STATUS;
  endfunction : is_mapped

  function automatic logic [31:0] widen(input logic [TIMER_WIDTH-1:0] value);
    return {{(32-TIMER_WIDTH){1'b0}}, value};
  endfunction : widen

  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign mapped = is_mapped(paddr);
  assign wr     = access && pwrite && !pslverr;
  assign rd     = access && !pwrite && !pslverr;

  assign wr_control    = wr && (paddr == compare_mode3_pkg::OFFSET_CONTROL);
  assign wr_timer      = wr && (paddr == compare_mode3_pkg::OFFSET_TIMER);
  assign wr_reload     = wr && (paddr == compare_mode3_pkg::OFFSET_RELOAD);
  assign wr_compare    = wr && (paddr == compare_mode3_pkg::OFFSET_COMPARE);
  assign wr_status     = wr && (paddr == compare_mode3_pkg::OFFSET_STATUS);
  // a read counts as an access to control as much as a write does
  assign touch_control = (wr || rd) && (paddr == compare_mode3_pkg::OFFSET_CONTROL);

  assign data_eq_compare = (pwdata[TIMER_WIDTH-1:0] == channel_compare_value);
  assign timer_load      = wr_timer;

  compare_timer_core #(
    .WIDTH (TIMER_WIDTH)
  ) u_core (
    .pclk                  (pclk),
    .presetn               (presetn),
    .run                   (control.run),
    .load                  (timer_load),
    .load_value            (pwdata[TIMER_WIDTH-1:0]),
    .reload_value          (timer_reload_value),
    .channel_compare_value (channel_compare_value),
    .count                 (count),
    .events                (events)
  );

  // no wait state: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && !is_mapped(paddr);
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      compare_mode3_pkg::OFFSET_CONTROL:
      begin
        next_rdata[compare_mode3_pkg::CTRL_RUN_BIT]   = control.run;
        next_rdata[compare_mode3_pkg::CTRL_MODE_LSB +: 2] = control.mode;
        next_rdata[compare_mode3_pkg::CTRL_QUIRK_BIT] = control.quirk_enable;
      end
      compare_mode3_pkg::OFFSET_TIMER:   next_rdata = widen(count);
      compare_mode3_pkg::OFFSET_RELOAD:  next_rdata = widen(timer_reload_value);
      compare_mode3_pkg::OFFSET_COMPARE: next_rdata = widen(channel_compare_value);
      compare_mode3_pkg::OFFSET_STATUS:
      begin
        next_rdata[compare_mode3_pkg::STAT_OUT_BIT]      = compare_out;
        next_rdata[compare_mode3_pkg::STAT_STUCK_BIT]    = stuck_low;
        next_rdata[compare_mode3_pkg::STAT_MATCH_BIT]    = match_flag;
        next_rdata[compare_mode3_pkg::STAT_OVERFLOW_BIT] = overflow_flag;
      end
      default:                           next_rdata = 32'h0000_0000;
    endcase
  end

  // read data latched in setup, stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite && mapped)
      prdata <= next_rdata;
    else if (setup)
      prdata <= 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control.run          <= compare_mode3_pkg::RESET_RUN;
      control.mode         <= compare_mode3_pkg::RESET_MODE;
      control.quirk_enable <= compare_mode3_pkg::RESET_QUIRK;
    end
    else if (wr_control)
    begin
      control.run          <= pwdata[compare_mode3_pkg::CTRL_RUN_BIT];
      control.mode         <= pwdata[compare_mode3_pkg::CTRL_MODE_LSB +: 2];
      control.quirk_enable <= pwdata[compare_mode3_pkg::CTRL_QUIRK_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_reload_value <= compare_mode3_pkg::RESET_RELOAD;
    else if (wr_reload)
      timer_reload_value <= pwdata[TIMER_WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_compare_value <= compare_mode3_pkg::RESET_COMPARE;
    else if (wr_compare)
      channel_compare_value <= pwdata[TIMER_WIDTH-1:0];
  end

  // back to back: setup directly follows the previous completing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_last <= 1'b0;
    else
      done_last <= access;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xfer_back_to_back <= 1'b0;
    else if (setup)
      xfer_back_to_back <= done_last;
  end

  // tracks reload write then timer write, both equal to compare, with no
  // idle cycle between transfers; any other access or a gap disarms it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq <= compare_mode3_pkg::SEQ_IDLE;
    else if (!psel && !done_last)
      seq <= compare_mode3_pkg::SEQ_IDLE;
    else if (access)
    begin
      unique case (seq)
        compare_mode3_pkg::SEQ_IDLE:
          seq <= (wr_reload && data_eq_compare) ? compare_mode3_pkg::SEQ_RELOAD_SEEN
                                                : compare_mode3_pkg::SEQ_IDLE;
        compare_mode3_pkg::SEQ_RELOAD_SEEN:
          // timer written first never arms, order matters
          seq <= (wr_timer && data_eq_compare && xfer_back_to_back)
                 ? compare_mode3_pkg::SEQ_ARMED
                 : ((wr_reload && data_eq_compare) ? compare_mode3_pkg::SEQ_RELOAD_SEEN
                                                   : compare_mode3_pkg::SEQ_IDLE);
        compare_mode3_pkg::SEQ_ARMED:
          seq <= (wr_reload && data_eq_compare) ? compare_mode3_pkg::SEQ_RELOAD_SEEN
                                                : compare_mode3_pkg::SEQ_IDLE;
      endcase
    end
  end

  // faithful to the flawed silicon while quirk_enable is set; clearing
  // that bit gives the corrected behaviour at the cost of compatibility
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stuck_low <= 1'b0;
    else if (touch_control && xfer_back_to_back && control.quirk_enable &&
             seq == compare_mode3_pkg::SEQ_ARMED)
      stuck_low <= 1'b1;
    else if (wr_timer || wr_reload ||
             (wr_status && pwdata[compare_mode3_pkg::STAT_STUCK_BIT]) ||
             (wr_control && !pwdata[compare_mode3_pkg::CTRL_QUIRK_BIT]))
      stuck_low <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_out <= 1'b0;
    else if (stuck_low || control.mode != compare_mode3_pkg::MODE_COMPARE3)
      compare_out <= 1'b0;
    else if (events.match && events.overflow)
      compare_out <= compare_out;
    else if (events.overflow)
      compare_out <= 1'b0;
    else if (events.match)
      compare_out <= 1'b1;
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      match_flag <= 1'b0;
    else if (events.match)
      match_flag <= 1'b1;
    else if (wr_status && pwdata[compare_mode3_pkg::STAT_MATCH_BIT])
      match_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_flag <= 1'b0;
    else if (events.overflow)
      overflow_flag <= 1'b1;
    else if (wr_status && pwdata[compare_mode3_pkg::STAT_OVERFLOW_BIT])
      overflow_flag <= 1'b0;
  end

endmodule : compare_mode3_output_control

// [compare_mode3_output_control_chk.sv]
`timescale 1ns/1ns
module compare_mode3_output_control_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        compare_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_st;
  assign rd_st = pready && !pwrite && paddr == 8'h10;
  property p_setup; psel && !penable |=> pready; endproperty
  a_setup: assert property (p_setup) else $error("no answer after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  endproperty
  a_err: assert property (p_err) else $error("wrong error response");
  property p_err_data; pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
  a_err_data: assert property (p_err_data) else $error("error read not zero");
  property p_pin; rd_st |-> prdata[0] == $past(compare_out); endproperty
  a_pin: assert property (p_pin) else $error("status pin bit wrong");
  property p_st_up; rd_st |-> prdata[31:4] == 28'h0000000; endproperty
  a_st_up: assert property (p_st_up) else $error("status upper bits set");
  property p_up; pready && !pwrite && paddr inside {8'h04, 8'h08, 8'h0C}
    |-> prdata[31:16] == 16'h0000; endproperty
  a_up: assert property (p_up) else $error("value upper bits set");
  // mode other than 3 parks the pin low, whatever the timer does; mode lands
  // on the completing edge, the pin one edge later
  property p_off; pready && pwrite && paddr == 8'h00 && pwdata[2:1] != 2'h3
    |-> ##2 !compare_out; endproperty
  a_off: assert property (p_off) else $error("pin high outside mode 3");
  // stuck seen at setup means the pin was already forced low at that edge
  property p_stuck; rd_st && prdata[1] |-> !compare_out; endproperty
  a_stuck: assert property (p_stuck) else $error("pin high while stuck");
endmodule : compare_mode3_output_control_chk

bind compare_mode3_output_control compare_mode3_output_control_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .compare_out(compare_out));

// [compare_mode3_pkg.sv]
package compare_mode3_pkg;

  localparam int unsigned TIMER_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH  = 8;

  // register byte offsets
  localparam logic [7:0] OFFSET_CONTROL = 8'h00;
  localparam logic [7:0] OFFSET_TIMER   = 8'h04;
  localparam logic [7:0] OFFSET_RELOAD  = 8'h08;
  localparam logic [7:0] OFFSET_COMPARE = 8'h0C;
  localparam logic [7:0] OFFSET_STATUS  = 8'h10;

  // control field positions
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_MODE_LSB  = 1;
  localparam int unsigned CTRL_QUIRK_BIT = 3;

  // status field positions
  localparam int unsigned STAT_OUT_BIT      = 0;
  localparam int unsigned STAT_STUCK_BIT    = 1;
  localparam int unsigned STAT_MATCH_BIT    = 2;
  localparam int unsigned STAT_OVERFLOW_BIT = 3;

  localparam logic [1:0] MODE_COMPARE3 = 2'h3;

  // values after reset
  localparam logic [15:0] RESET_TIMER   = 16'h0000;
  localparam logic [15:0] RESET_RELOAD  = 16'h0000;
  localparam logic [15:0] RESET_COMPARE = 16'h0000;
  localparam logic        RESET_RUN     = 1'b0;
  localparam logic [1:0]  RESET_MODE    = 2'h0;
  localparam logic        RESET_QUIRK   = 1'b1;

  typedef struct packed {
    logic       quirk_enable;
    logic [1:0] mode;
    logic       run;
  } control_t;

  typedef struct packed {
    logic match;
    logic overflow;
  } timer_event_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RELOAD_SEEN,
    SEQ_ARMED
  } preload_seq_t;

endpackage : compare_mode3_pkg

// [compare_pin_load.sv]
`timescale 1ns/1ns
module compare_pin_load (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   pin,
  output int unsigned rises
);
  logic last;
  // counts rising pin edges, as a counter input on the board would
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last  <= 1'b0;
      rises <= 0;
    end
    else
    begin
      last <= pin;
      if (pin && !last)
        rises <= rises + 1;
    end
  end
endmodule : compare_pin_load

// [compare_timer_core.sv]
`timescale 1ns/1ns
module compare_timer_core #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           run,
  input  wire logic                           load,
  input  wire logic [WIDTH-1:0]               load_value,
  input  wire logic [WIDTH-1:0]               reload_value,
  input  wire logic [WIDTH-1:0]               channel_compare_value,
  output logic [WIDTH-1:0]                    count,
  output compare_mode3_pkg::timer_event_t     events
);

  logic [WIDTH-1:0] next_count;
  logic             wrap;

  assign wrap = (count == {WIDTH{1'b1}});

  always_comb
  begin
    if (wrap)
      next_count = reload_value;
    else
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // a software load wins over counting in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= compare_mode3_pkg::RESET_TIMER;
    else if (load)
      count <= load_value;
    else if (run)
      count <= next_count;
  end

  // match judged on the value the step lands on, so a reload equal to
  // compare gives match and overflow in one event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      events <= '0;
    else
    begin
      events.overflow <= run && !load && wrap;
      events.match    <= run && !load && (next_count == channel_compare_value);
    end
  end

endmodule : compare_timer_core

// [test_compare_mode3_output_control.sv]
`timescale 1ns/1ns
module test_compare_mode3_output_control;
  localparam logic [7:0] CT = compare_mode3_pkg::OFFSET_CONTROL;
  localparam logic [7:0] TM = compare_mode3_pkg::OFFSET_TIMER;
  localparam logic [7:0] RL = compare_mode3_pkg::OFFSET_RELOAD;
  localparam logic [7:0] ST = compare_mode3_pkg::OFFSET_STATUS;
  localparam logic [7:0] CP = compare_mode3_pkg::OFFSET_COMPARE;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, compare_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_errors, checks, n;
  int unsigned rises, r0;
  compare_mode3_output_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .compare_out(compare_out));
  compare_pin_load load (.pclk(pclk), .presetn(presetn), .pin(compare_out), .rises(rises));
  always #5 pclk = ~pclk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // called right after an edge; leaves psel up so a following call starts
  // its setup at once, back to back; idle releases the bus
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      report_and_stop;
    end
    q = prdata;
    penable <= 1'b0;
  endtask : xfer
  task idle;
    psel <= 1'b0;
    @(posedge pclk);
  endtask : idle
  task wait_pin(input logic v);
    n = 0;
    while (compare_out !== v)
    begin
      if (n == 40)
      begin
        n_errors++;
        report_and_stop;
      end
      @(posedge pclk);
      n++;
    end
  endtask : wait_pin
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(0, CT, 32'h0);
    chk(q, 32'h00000008);
    xfer(0, 8'h14, 32'h0);
    chk(q, 32'h00000000);
    xfer(1, CP, 32'h0000FFF8);
    xfer(1, RL, 32'h0000FFF0);
    xfer(1, TM, 32'h0000FFF0);
    xfer(1, CT, 32'h00000007);
    xfer(0, RL, 32'h0);
    chk(q, 32'h0000FFF0);
    idle;
    wait_pin(1);
    wait_pin(0);
    chk(32'(n), 32'h00000008);
    $display("test match and overflow done");
    wait_pin(1);
    xfer(1, RL, 32'h0000FFF8);
    idle;
    r0 = rises;
    repeat (40) @(posedge pclk);
    chk(32'(rises - r0), 32'h0);
    xfer(0, ST, 32'h0);
    chk(q & 32'h3, 32'h00000001);
    $display("test equal reload done");
    // stop writes keep the quirk bit, the stuck arm reads the old value
    xfer(1, CT, 32'h00000008);
    xfer(1, RL, 32'h0000FFF8);
    xfer(1, TM, 32'h0000FFF8);
    xfer(1, CT, 32'h0000000F);
    idle;
    repeat (40) @(posedge pclk);
    chk({31'h0, compare_out}, 32'h0);
    xfer(0, ST, 32'h0);
    chk(q & 32'h3, 32'h00000002);
    $display("test stuck low done");
    xfer(1, CT, 32'h00000008);
    xfer(1, TM, 32'h0000FFF8);
    xfer(1, RL, 32'h0000FFF8);
    xfer(1, CT, 32'h0000000F);
    xfer(0, ST, 32'h0);
    chk(q & 32'h2, 32'h0);
    // a compare write leaves stuck alone, so a rise proves normal toggling
    r0 = rises;
    xfer(1, CP, 32'h0000FFFC);
    idle;
    wait_pin(1);
    repeat (2) @(posedge pclk);
    chk(32'(rises - r0), 32'h1);
    $display("test swapped order done");
    xfer(1, CT, 32'h00000008);
    xfer(1, CP, 32'h0000FFF8);
    xfer(1, RL, 32'h0000FFF8);
    xfer(1, TM, 32'h0000FFF8);
    idle;
    xfer(1, CT, 32'h0000000F);
    xfer(0, ST, 32'h0);
    chk(q & 32'h2, 32'h0);
    $display("test idle slot done");
    xfer(1, CT, 32'h00000008);
    xfer(1, RL, 32'h0000FFF8);
    xfer(1, TM, 32'h0000FFF7);
    r0 = rises;
    xfer(1, CT, 32'h0000000F);
    idle;
    wait_pin(1);
    repeat (2) @(posedge pclk);
    chk(32'(rises - r0), 32'h1);
    xfer(0, ST, 32'h0);
    chk(q & 32'h3, 32'h00000001);
    idle;
    $display("test preload minus one done");
    report_and_stop;
  end
endmodule : test_compare_mode3_output_control
